// *** common/bdcu_consts.vh ***
// constants for the background debug command unit
`ifndef BDCU_CONSTS_VH
`define BDCU_CONSTS_VH

// command codes on cmd_code_i
`define BDCU_CMD_NULL 4'h0
`define BDCU_CMD_RD_DATA 4'h1
`define BDCU_CMD_RD_ADDR 4'h2
`define BDCU_CMD_WR_DATA 4'h3
`define BDCU_CMD_WR_ADDR 4'h4
`define BDCU_CMD_RD_SYS 4'h5
`define BDCU_CMD_WR_SYS 4'h6
`define BDCU_CMD_MEM_RD 4'h7
`define BDCU_CMD_MEM_WR 4'h8
`define BDCU_CMD_DUMP 4'h9
`define BDCU_CMD_FILL 4'hA
`define BDCU_CMD_RESUME 4'hB
`define BDCU_CMD_PATCH 4'hC
`define BDCU_CMD_PERIPH_RST 4'hD

// system register indices
`define BDCU_SYS_PC 3'h0
`define BDCU_SYS_SR 3'h1
`define BDCU_SYS_SP 3'h2
`define BDCU_SYS_SRC_SPACE 3'h3
`define BDCU_SYS_DST_SPACE 3'h4
`define BDCU_SYS_VBR 3'h5
`define BDCU_SYS_COUNT 8

// access size codes
`define BDCU_SIZE_BYTE 2'h0
`define BDCU_SIZE_WORD 2'h1
`define BDCU_SIZE_LONG 2'h2

// reset values
`define BDCU_SR_RESET 32'h0000_2700
`define BDCU_ZERO 32'h0000_0000

// peripheral reset pulse, in clock cycles
`define BDCU_PRST_CYCLES 11'd512

// pipeline refill counter load; the refill wait lasts one clock cycle more
`define BDCU_REFILL_CYCLES 10'd4

`endif

// *** verilog/bdcu_regfile.v ***
// register file holding data and address registers, registered read port
`default_nettype none

module bdcu_regfile (
    input wire clk_i,
    input wire arst_n_i,
    input wire wr_en_i,
    input wire [3:0] wr_idx_i,
    input wire [31:0] wr_data_i,
    input wire [3:0] rd_idx_i,
    output reg [31:0] rd_data_o
);

reg [31:0] mem [0:15];
integer i;

always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        for (i = 0; i < 16; i = i + 1) begin
            mem[i] <= 32'h0000_0000;
        end
        rd_data_o <= 32'h0000_0000;
    end else begin
        if (wr_en_i) begin
            mem[wr_idx_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_idx_i];
    end
end

endmodule // bdcu_regfile

`default_nettype wire

// *** verilog/bdcu_top.v ***
// background debug command unit: decodes host commands and drives core state
`include "bdcu_consts.vh"
`default_nettype none

module bdcu_top (
    input wire clk_i,
    input wire arst_n_i,
    // command from the serial deframer, same clock
    input wire cmd_valid_i,
    input wire [3:0] cmd_code_i,
    input wire [3:0] cmd_reg_i,
    input wire [1:0] cmd_size_i,
    input wire [31:0] cmd_addr_i,
    input wire [31:0] cmd_data_i,
    output reg cmd_ready_o,
    // answer toward the serial framer
    output reg resp_valid_o,
    output reg [31:0] resp_data_o,
    // memory master
    output reg mem_req_o,
    output reg mem_we_o,
    output reg [31:0] mem_addr_o,
    output reg [2:0] mem_space_o,
    output reg [1:0] mem_size_o,
    output reg [31:0] mem_wdata_o,
    input wire mem_ack_i,
    input wire [31:0] mem_rdata_i,
    // core control
    output reg core_flush_o,
    output reg core_run_o,
    output reg [31:0] core_pc_o,
    // external reset line, active low
    output reg periph_rst_n_o
);

// ==========================================================================
// states
localparam [6:0] ST_IDLE = 7'b0000001;
localparam [6:0] ST_READ_DATA_REG_CMD = 7'b0000010;
localparam [6:0] ST_MEM = 7'b0000100;
localparam [6:0] ST_PUSH = 7'b0001000;
localparam [6:0] ST_REFILL = 7'b0010000;
localparam [6:0] ST_PRST = 7'b0100000;
localparam [6:0] ST_RESP = 7'b1000000;

reg [6:0] state;
reg [31:0] sys_reg [0:`BDCU_SYS_COUNT-1];
reg [31:0] blk_addr;
reg [1:0] blk_size;
reg [9:0] count;
// counter ends at zero, so the load is one short of the pulse length
localparam [10:0] PRST_LAST = `BDCU_PRST_CYCLES - 11'd1;

wire [31:0] rf_rdata;
wire [3:0] rf_ridx = {(cmd_code_i == `BDCU_CMD_RD_ADDR), cmd_reg_i[2:0]};
reg rf_we;
reg [3:0] rf_widx;
reg [31:0] rf_wdata;

// ==========================================================================
// helpers
function [31:0] size_step;
    input [1:0] sz;
    begin
        case (sz)
            `BDCU_SIZE_BYTE: size_step = 32'h0000_0001;
            `BDCU_SIZE_WORD: size_step = 32'h0000_0002;
            default: size_step = 32'h0000_0004;
        endcase
    end
endfunction

function [31:0] size_mask;
    input [1:0] sz;
    input [31:0] d;
    begin
        case (sz)
            `BDCU_SIZE_BYTE: size_mask = {24'h000000, d[7:0]};
            `BDCU_SIZE_WORD: size_mask = {16'h0000, d[15:0]};
            default: size_mask = d;
        endcase
    end
endfunction

bdcu_regfile u_regfile (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .wr_en_i(rf_we),
    .wr_idx_i(rf_widx),
    .wr_data_i(rf_wdata),
    .rd_idx_i(rf_ridx),
    .rd_data_o(rf_rdata)
);

// ==========================================================================
// register file write port
always @* begin
    rf_we = 1'b0;
    rf_widx = cmd_reg_i;
    rf_wdata = cmd_data_i;
    if (cmd_ready_o && cmd_valid_i) begin
        if (cmd_code_i == `BDCU_CMD_WR_DATA) begin
            rf_we = 1'b1;
            rf_widx = {1'b0, cmd_reg_i[2:0]};
        end else if (cmd_code_i == `BDCU_CMD_WR_ADDR) begin
            rf_we = 1'b1;
            rf_widx = {1'b1, cmd_reg_i[2:0]};
        end
    end
end

// ==========================================================================
// command sequencer
integer k;

always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        state <= ST_IDLE;
        for (k = 0; k < `BDCU_SYS_COUNT; k = k + 1) begin
            sys_reg[k] <= `BDCU_ZERO;
        end
        sys_reg[`BDCU_SYS_SR] <= `BDCU_SR_RESET;
        blk_addr <= `BDCU_ZERO;
        blk_size <= `BDCU_SIZE_LONG;
        count <= 10'd0;
        cmd_ready_o <= 1'b0;
        resp_valid_o <= 1'b0;
        resp_data_o <= `BDCU_ZERO;
        mem_req_o <= 1'b0;
        mem_we_o <= 1'b0;
        mem_addr_o <= `BDCU_ZERO;
        mem_space_o <= 3'h0;
        mem_size_o <= `BDCU_SIZE_LONG;
        mem_wdata_o <= `BDCU_ZERO;
        core_flush_o <= 1'b0;
        core_run_o <= 1'b0;
        core_pc_o <= `BDCU_ZERO;
        periph_rst_n_o <= 1'b1;
    end else begin
        resp_valid_o <= 1'b0;
        core_flush_o <= 1'b0;
        core_pc_o <= sys_reg[`BDCU_SYS_PC];
        case (state)
            ST_IDLE: begin
                cmd_ready_o <= 1'b1;
                if (cmd_ready_o && cmd_valid_i) begin
                    cmd_ready_o <= 1'b0;
                    case (cmd_code_i)
                        `BDCU_CMD_RD_DATA, `BDCU_CMD_RD_ADDR: begin
                            state <= ST_READ_DATA_REG_CMD;
                        end
                        `BDCU_CMD_WR_DATA, `BDCU_CMD_WR_ADDR: begin
                            state <= ST_IDLE;
                        end
                        `BDCU_CMD_RD_SYS: begin
                            resp_data_o <= sys_reg[cmd_reg_i[2:0]];
                            state <= ST_RESP;
                        end
                        `BDCU_CMD_WR_SYS: begin
                            sys_reg[cmd_reg_i[2:0]] <= cmd_data_i;
                            state <= ST_IDLE;
                        end
                        `BDCU_CMD_MEM_RD, `BDCU_CMD_MEM_WR: begin
                            // full 32-bit address starts a new block
                            blk_addr <= cmd_addr_i + size_step(cmd_size_i);
                            blk_size <= cmd_size_i;
                            mem_req_o <= 1'b1;
                            mem_we_o <= (cmd_code_i == `BDCU_CMD_MEM_WR);
                            mem_addr_o <= cmd_addr_i;
                            mem_size_o <= cmd_size_i;
                            mem_wdata_o <= size_mask(cmd_size_i, cmd_data_i);
                            if (cmd_code_i == `BDCU_CMD_MEM_WR) begin
                                mem_space_o <= sys_reg[`BDCU_SYS_DST_SPACE][2:0];
                            end else begin
                                mem_space_o <= sys_reg[`BDCU_SYS_SRC_SPACE][2:0];
                            end
                            state <= ST_MEM;
                        end
                        `BDCU_CMD_DUMP, `BDCU_CMD_FILL: begin
                            blk_addr <= blk_addr + size_step(blk_size);
                            mem_req_o <= 1'b1;
                            mem_we_o <= (cmd_code_i == `BDCU_CMD_FILL);
                            mem_addr_o <= blk_addr;
                            mem_size_o <= blk_size;
                            mem_wdata_o <= size_mask(blk_size, cmd_data_i);
                            if (cmd_code_i == `BDCU_CMD_FILL) begin
                                mem_space_o <= sys_reg[`BDCU_SYS_DST_SPACE][2:0];
                            end else begin
                                mem_space_o <= sys_reg[`BDCU_SYS_SRC_SPACE][2:0];
                            end
                            state <= ST_MEM;
                        end
                        `BDCU_CMD_RESUME: begin
                            core_flush_o <= 1'b1;
                            count <= `BDCU_REFILL_CYCLES;
                            state <= ST_REFILL;
                        end
                        `BDCU_CMD_PATCH: begin
                            // stack grows down: pre-decrement then push pc
                            sys_reg[`BDCU_SYS_SP] <= sys_reg[`BDCU_SYS_SP] - 32'h0000_0004;
                            mem_req_o <= 1'b1;
                            mem_we_o <= 1'b1;
                            mem_addr_o <= sys_reg[`BDCU_SYS_SP] - 32'h0000_0004;
                            mem_size_o <= `BDCU_SIZE_LONG;
                            mem_wdata_o <= sys_reg[`BDCU_SYS_PC];
                            mem_space_o <= sys_reg[`BDCU_SYS_DST_SPACE][2:0];
                            state <= ST_PUSH;
                        end
                        `BDCU_CMD_PERIPH_RST: begin
                            periph_rst_n_o <= 1'b0;
                            count <= PRST_LAST[9:0];
                            state <= ST_PRST;
                        end
                        default: begin
                            state <= ST_IDLE;
                        end
                    endcase
                end
            end
            ST_READ_DATA_REG_CMD: begin
                // register file read data lands one cycle later
                resp_data_o <= rf_rdata;
                state <= ST_RESP;
            end
            ST_MEM: begin
                if (mem_ack_i) begin
                    mem_req_o <= 1'b0;
                    if (mem_we_o) begin
                        state <= ST_IDLE;
                    end else begin
                        resp_data_o <= size_mask(mem_size_o, mem_rdata_i);
                        state <= ST_RESP;
                    end
                end
            end
            ST_PUSH: begin
                if (mem_ack_i) begin
                    mem_req_o <= 1'b0;
                    // patch code entry is taken from the pc, which the host set
                    core_flush_o <= 1'b1;
                    count <= `BDCU_REFILL_CYCLES;
                    state <= ST_REFILL;
                end
            end
            ST_REFILL: begin
                if (count == 10'd0) begin
                    core_run_o <= 1'b1;
                    state <= ST_IDLE;
                end else begin
                    count <= count - 10'd1;
                end
            end
            ST_PRST: begin
                if (count == 10'd0) begin
                    periph_rst_n_o <= 1'b1;
                    state <= ST_IDLE;
                end else begin
                    count <= count - 10'd1;
                end
            end
            ST_RESP: begin
                resp_valid_o <= 1'b1;
                state <= ST_IDLE;
            end
            default: begin
                state <= ST_IDLE;
            end
        endcase
    end
end

endmodule // bdcu_top

`default_nettype wire

// *** dv/bdcu_checker.sv ***
// concurrent checks on the debug command unit ports
`include "bdcu_consts.vh"
`default_nettype none
module bdcu_checker (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic cmd_valid_i,
    input wire logic [3:0] cmd_code_i,
    input wire logic cmd_ready_o,
    input wire logic resp_valid_o,
    input wire logic mem_req_o,
    input wire logic mem_we_o,
    input wire logic mem_ack_i,
    input wire logic [31:0] mem_addr_o,
    input wire logic core_flush_o,
    input wire logic core_run_o,
    input wire logic [31:0] core_pc_o,
    input wire logic periph_rst_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tk;
    logic [9:0] low_n;
    assign tk = cmd_valid_i && cmd_ready_o;
    // counts low cycles of the reset pulse; cleared while the line is high
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) low_n <= 10'h000;
        else low_n <= periph_rst_n_o ? 10'h000 : low_n + 10'h001;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    // ==========================================================
    // assertions
    take_drop_a: assert property (tk |=> !cmd_ready_o)
        else $error("ready stayed high after a take");
    resp_busy_a: assert property (resp_valid_o |-> !cmd_ready_o)
        else $error("answer came after ready returned");
    req_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
        else $error("memory request dropped or moved");
    rd_answer_a: assert property (mem_req_o && mem_ack_i && !mem_we_o |-> ##[1:2] resp_valid_o)
        else $error("memory read gave no answer");
    sys_answer_a: assert property (tk && cmd_code_i == `BDCU_CMD_RD_SYS |-> ##[1:3] resp_valid_o)
        else $error("system read gave no answer");
    reg_answer_a: assert property (tk && (cmd_code_i == `BDCU_CMD_RD_DATA || cmd_code_i == `BDCU_CMD_RD_ADDR)
        |-> ##[2:4] resp_valid_o)
        else $error("register read gave no answer");
    null_quiet_a: assert property (tk && cmd_code_i == `BDCU_CMD_NULL
        |=> (!mem_req_o && !resp_valid_o && !core_flush_o && periph_rst_n_o)[*3])
        else $error("null command had an effect");
    go_run_a: assert property (tk && cmd_code_i == `BDCU_CMD_RESUME |-> ##[1:2] core_flush_o ##[3:7] core_run_o)
        else $error("resume did not flush then run");
    rst_start_a: assert property (tk && cmd_code_i == `BDCU_CMD_PERIPH_RST |-> ##[1:2] !periph_rst_n_o)
        else $error("reset pulse did not start");
    rst_len_a: assert property ($rose(periph_rst_n_o) |-> low_n == 10'h200)
        else $error("reset pulse length wrong");
    rst_core_a: assert property (!periph_rst_n_o |-> !core_flush_o && !mem_req_o && $stable(core_pc_o))
        else $error("core disturbed by reset pulse");
    cover property (tk && cmd_code_i == `BDCU_CMD_DUMP);
    cover property ($rose(periph_rst_n_o));
    cover property ($rose(core_run_o));
endmodule // bdcu_checker
bind bdcu_top bdcu_checker u_chk (.*);
`default_nettype wire

// *** dv/bdcu_mem_model.sv ***
// memory slave facing the command unit, with a settable wait
`default_nettype none
module bdcu_mem_model (
    input wire logic clk_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [31:0] addr_i,
    input wire logic [2:0] space_i,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] dly_i,
    output logic ack_o,
    output logic [31:0] rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [0:63];
    logic [2:0] last_space = 3'h0;
    logic [3:0] wait_n = 4'h0;
    initial ack_o = 1'b0;
    initial rdata_o = 32'h0;
    always @(posedge clk_i) begin
        ack_o <= 1'b0;
        // read data toggles outside the ack so stale values never match
        rdata_o <= ~rdata_o;
        if (req_i && !ack_o) begin
            if (wait_n < dly_i) wait_n <= wait_n + 4'h1;
            else begin
                ack_o <= 1'b1;
                wait_n <= 4'h0;
                last_space <= space_i;
                if (we_i) mem[addr_i[7:2]] <= wdata_i;
                else rdata_o <= mem[addr_i[7:2]];
            end
        end
    end
endmodule // bdcu_mem_model
`default_nettype wire

// *** dv/bdcu_top_tb.sv ***
// self-checking bench for the debug command unit
`include "bdcu_consts.vh"
`default_nettype none
module bdcu_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic cmd_valid_i = 1'b0;
    logic [3:0] cmd_code_i = 4'h0;
    logic [3:0] cmd_reg_i = 4'h0;
    logic [1:0] cmd_size_i = 2'h0;
    logic [31:0] cmd_addr_i = 32'h0;
    logic [31:0] cmd_data_i = 32'h0;
    logic cmd_ready_o, resp_valid_o, mem_req_o, mem_we_o, mem_ack_i, core_flush_o, core_run_o, periph_rst_n_o;
    logic [31:0] resp_data_o, mem_addr_o, mem_wdata_o, mem_rdata_i, core_pc_o, got;
    logic [2:0] mem_space_o;
    logic [1:0] mem_size_o;
    logic [3:0] dly = 4'h3;
    int miscompares = 0;
    int comparisons = 0;
    int low_n = 0;
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) if (periph_rst_n_o === 1'b0) low_n <= low_n + 1;
    bdcu_top DUT (.*);
    bdcu_mem_model mem_m (.clk_i(clk_i), .req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o),
        .space_i(mem_space_o), .wdata_i(mem_wdata_o), .dly_i(dly), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
    // ==========================================================
    // shared tasks
    task automatic cmd(input logic [3:0] c, input logic [3:0] r, input logic [31:0] a, d, input logic [1:0] s);
        int n;
        got = 32'hXXXX_XXXX;
        cmd_valid_i <= 1'b1;
        cmd_code_i <= c;
        cmd_reg_i <= r;
        cmd_addr_i <= a;
        cmd_data_i <= d;
        cmd_size_i <= s;
        n = 0;
        do @(posedge clk_i); while (cmd_ready_o !== 1'b1 && ++n < 50);
        if (n >= 50) miscompares++;
        cmd_valid_i <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_i);
            if (resp_valid_o === 1'b1) got = resp_data_o;
        end while (cmd_ready_o !== 1'b1 && ++n < 700);
        if (n >= 700) miscompares++;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_regs;
        cmd(`BDCU_CMD_WR_DATA, 4'h2, 32'h0, 32'hA5A5_0001, 2'h0);
        cmd(`BDCU_CMD_WR_ADDR, 4'h2, 32'h0, 32'h0000_1234, 2'h0);
        cmd(`BDCU_CMD_NULL, 4'h2, 32'h10, 32'hFFFF_FFFF, 2'h0);
        cmd(`BDCU_CMD_RD_DATA, 4'h2, 32'h0, 32'h0, 2'h0);
        chk("data reg", 32'hA5A5_0001, got);
        cmd(`BDCU_CMD_RD_ADDR, 4'h2, 32'h0, 32'h0, 2'h0);
        chk("addr reg", 32'h0000_1234, got);
        $display("test regs done");
    endtask
    task automatic t_sys;
        cmd(`BDCU_CMD_RD_SYS, {1'b0, `BDCU_SYS_SR}, 32'h0, 32'h0, 2'h0);
        chk("sr reset", `BDCU_SR_RESET, got);
        cmd(`BDCU_CMD_WR_SYS, {1'b0, `BDCU_SYS_SP}, 32'h0, 32'h0000_0080, 2'h0);
        cmd(`BDCU_CMD_RD_SYS, {1'b0, `BDCU_SYS_SP}, 32'h0, 32'h0, 2'h0);
        chk("sp", 32'h0000_0080, got);
        cmd(`BDCU_CMD_WR_SYS, {1'b0, `BDCU_SYS_SRC_SPACE}, 32'h0, 32'h0000_0005, 2'h0);
        cmd(`BDCU_CMD_WR_SYS, {1'b0, `BDCU_SYS_DST_SPACE}, 32'h0, 32'h0000_0003, 2'h0);
        $display("test sys done");
    endtask
    task automatic t_go;
        cmd(`BDCU_CMD_WR_SYS, {1'b0, `BDCU_SYS_PC}, 32'h0, 32'h0000_0800, 2'h0);
        chk("idle run", 32'h0, {31'h0, core_run_o});
        cmd(`BDCU_CMD_RESUME, 4'h0, 32'h0, 32'h0, 2'h0);
        repeat (8) @(posedge clk_i);
        chk("run", 32'h1, {31'h0, core_run_o});
        chk("pc out", 32'h0000_0800, core_pc_o);
        $display("test resume done");
    endtask
    task automatic t_mem;
        cmd(`BDCU_CMD_MEM_WR, 4'h0, 32'h10, 32'h1122_3344, `BDCU_SIZE_LONG);
        chk("wr space", 32'h3, {29'h0, mem_m.last_space});
        chk("wr data", 32'h1122_3344, mem_m.mem[4]);
        cmd(`BDCU_CMD_FILL, 4'h0, 32'h0, 32'h5566_7788, `BDCU_SIZE_LONG);
        chk("fill", 32'h5566_7788, mem_m.mem[5]);
        dly <= 4'h0;
        cmd(`BDCU_CMD_MEM_RD, 4'h0, 32'h10, 32'h0, `BDCU_SIZE_LONG);
        chk("rd data", 32'h1122_3344, got);
        chk("rd space", 32'h5, {29'h0, mem_m.last_space});
        cmd(`BDCU_CMD_DUMP, 4'h0, 32'h0, 32'h0, `BDCU_SIZE_LONG);
        chk("dump", 32'h5566_7788, got);
        cmd(`BDCU_CMD_MEM_RD, 4'h0, 32'h10, 32'h0, `BDCU_SIZE_BYTE);
        chk("rd byte", 32'h0000_0044, got);
        chk("byte size", {30'h0, `BDCU_SIZE_BYTE}, mem_size_o);
        cmd(`BDCU_CMD_MEM_RD, 4'h0, 32'h10, 32'h0, `BDCU_SIZE_WORD);
        chk("rd word", 32'h0000_3344, got);
        chk("word size", {30'h0, `BDCU_SIZE_WORD}, mem_size_o);
        $display("test memory done");
    endtask
    task automatic t_patch;
        cmd(`BDCU_CMD_WR_SYS, {1'b0, `BDCU_SYS_PC}, 32'h0, 32'h0000_0400, 2'h0);
        cmd(`BDCU_CMD_PATCH, 4'h0, 32'h0, 32'h0, 2'h0);
        chk("pushed pc", 32'h0000_0400, mem_m.mem[31]);
        cmd(`BDCU_CMD_RD_SYS, {1'b0, `BDCU_SYS_SP}, 32'h0, 32'h0, 2'h0);
        chk("sp after", 32'h0000_007C, got);
        $display("test patch done");
    endtask
    task automatic t_prst;
        low_n <= 0;
        cmd(`BDCU_CMD_PERIPH_RST, 4'h0, 32'h0, 32'h0, 2'h0);
        for (int i = 0; i < 600 && periph_rst_n_o !== 1'b1; i++) @(posedge clk_i);
        chk("pulse len", 32'h0000_0200, low_n);
        chk("pc kept", 32'h0000_0400, core_pc_o);
        cmd(`BDCU_CMD_RD_DATA, 4'h2, 32'h0, 32'h0, 2'h0);
        chk("data kept", 32'hA5A5_0001, got);
        $display("test periph reset done");
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        arst_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        t_regs();
        t_sys();
        t_go();
        t_mem();
        t_patch();
        t_prst();
        final_report();
    end
    // watchdog: the tests need well under a thousand cycles
    initial begin
        #160000;
        miscompares++;
        final_report();
    end
endmodule // bdcu_top_tb
`default_nettype wire
